// ===== logic/iprs_top.sv
// Operation
// - of 27 remap registers (14 input, 13 output) this block holds 5.
// - selector writes take effect only while the pin configuration lock is 0.
// - a selector holding n routes remappable pin n to its peripheral input.
// - register 0 holds the external interrupt 1 selector in bits 12 to 8.
// - register 0 reads zero in bits 15 to 13 and 7 to 0.
// - register 1 holds the interrupt 2 selector in bits 4 to 0, rest zero.
// - register 3 holds timer 3 clock select in 12 to 8 and timer 2 in 4 to 0.
// - register 4 holds timer 5 clock select in 12 to 8 and timer 4 in 4 to 0.
// - register 7 holds capture 2 select in 12 to 8 and capture 1 in 4 to 0.
// - dual selector registers read zero in bits 15 to 13 and 7 to 5.
// - every selector resets to 11111, tying its peripheral input low.
// - the lock changes only after 46h then 57h reach the control low byte.
// - a write blocked by the lock completes with an okay response.
// - with the single session option, a set lock stays set until reset.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "iprs_defines.svh"

module iprs_top
  import iprs_pkg::*;
#(
  parameter int NUM_PINS = 31
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // configuration and status
  input wire logic single_session_lock_cfg,
  output logic pin_config_lock,
  // remappable pins
  input wire logic [NUM_PINS-1:0] pin_in,
  // peripheral inputs
  output logic ext_irq_one,
  output logic ext_irq_two,
  output logic timer_two_ext_clk,
  output logic timer_three_ext_clk,
  output logic timer_four_ext_clk,
  output logic timer_five_ext_clk,
  output logic capture_one_input,
  output logic capture_two_input
);

  // ****************************************
  // helper functions
  // ****************************************

  // reset image of the whole state
  function automatic iprs_state_s reset_state();
    iprs_state_s r;
    r = '0;
    r.awready = 1'b1;
    r.wready = 1'b1;
    r.arready = 1'b1;
    r.seq = IPRS_IDLE;
    r.lock = `IPRS_LOCK_RESET;
    for (int i = 0; i < 8; i++) begin
      r.sel[i] = `IPRS_SEL_RESET;
    end
    return r;
  endfunction : reset_state

  // read word with a hit flag on top
  function automatic logic [32:0] rd_word(logic [7:0] a, iprs_state_s st);
    case (a)
      `IPRS_OFF_IRQ1: return {1'b1, 19'h0_0000, st.sel[0], 8'h00};
      `IPRS_OFF_IRQ2: return {1'b1, 27'h000_0000, st.sel[1]};
      `IPRS_OFF_TMR23:
        return {1'b1, 19'h0_0000, st.sel[3], 3'h0, st.sel[2]};
      `IPRS_OFF_TMR45:
        return {1'b1, 19'h0_0000, st.sel[5], 3'h0, st.sel[4]};
      `IPRS_OFF_CAP12:
        return {1'b1, 19'h0_0000, st.sel[7], 3'h0, st.sel[6]};
      `IPRS_OFF_OSC: return {1'b1, 24'h00_0000, 1'b0, st.lock, 6'h00};
      default: return {1'b0, 32'h0000_0000};
    endcase
  endfunction : rd_word

  // field update under its byte lane; other bits are dropped
  function automatic iprs_sel_t upd(iprs_sel_t old, logic [4:0] v,
                                    logic lane);
    return lane ? v : old;
  endfunction : upd

  // pin selection, absent pins read as ground
  function automatic logic route(logic [NUM_PINS-1:0] p, iprs_sel_t s);
    if (int'(s) < NUM_PINS) begin
      return p[s];
    end
    return 1'b0;
  endfunction : route

  // ****************************************
  // state
  // ****************************************
  iprs_state_s s_q;
  iprs_state_s s_d;
  logic wr_do;
  logic [32:0] rd_w;
  logic [32:0] wr_w;
  logic [7:0] new_low;

  // write performs once both address and data are held
  assign wr_do = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign rd_w = rd_word(araddr, s_q);
  assign wr_w = rd_word(s_q.awaddr, s_q);
  assign new_low = s_q.wdata[7:0];

  // next state
  always_comb begin
    s_d = s_q;
    // read channel
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_w[31:0];
      s_d.rresp = rd_w[32] ? `IPRS_RESP_OKAY : `IPRS_RESP_SLVERR;
    end
    s_d.arready = !s_d.rvalid;
    // write response retires
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    // capture address and data in either order
    if (awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    // perform the write
    if (wr_do) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      // locked writes still answer okay
      s_d.bresp = wr_w[32] ? `IPRS_RESP_OKAY : `IPRS_RESP_SLVERR;
      // selector registers, only while unlocked
      if (!s_q.lock) begin
        unique case (s_q.awaddr)
          `IPRS_OFF_IRQ1: begin
            s_d.sel[0] = upd(s_q.sel[0], s_q.wdata[12:8], s_q.wstrb[1]);
          end
          `IPRS_OFF_IRQ2: begin
            s_d.sel[1] = upd(s_q.sel[1], s_q.wdata[4:0], s_q.wstrb[0]);
          end
          `IPRS_OFF_TMR23: begin
            s_d.sel[3] = upd(s_q.sel[3], s_q.wdata[12:8], s_q.wstrb[1]);
            s_d.sel[2] = upd(s_q.sel[2], s_q.wdata[4:0], s_q.wstrb[0]);
          end
          `IPRS_OFF_TMR45: begin
            s_d.sel[5] = upd(s_q.sel[5], s_q.wdata[12:8], s_q.wstrb[1]);
            s_d.sel[4] = upd(s_q.sel[4], s_q.wdata[4:0], s_q.wstrb[0]);
          end
          `IPRS_OFF_CAP12: begin
            s_d.sel[7] = upd(s_q.sel[7], s_q.wdata[12:8], s_q.wstrb[1]);
            s_d.sel[6] = upd(s_q.sel[6], s_q.wdata[4:0], s_q.wstrb[0]);
          end
          default: begin
          end
        endcase
      end
      // unlock sequence on the control low byte
      if (s_q.awaddr == `IPRS_OFF_OSC && s_q.wstrb[0]) begin
        unique case (s_q.seq)
          IPRS_IDLE: begin
            s_d.seq = (new_low == `IPRS_KEY_ONE) ? IPRS_KEY1_SEEN
                                                 : IPRS_IDLE;
          end
          IPRS_KEY1_SEEN: begin
            if (new_low == `IPRS_KEY_TWO) begin
              s_d.seq = IPRS_ARMED;
            end else if (new_low == `IPRS_KEY_ONE) begin
              s_d.seq = IPRS_KEY1_SEEN;
            end else begin
              s_d.seq = IPRS_IDLE;
            end
          end
          IPRS_ARMED: begin
            s_d.seq = IPRS_IDLE;
            // one-way option keeps a set lock set
            if (!(single_session_lock_cfg && s_q.lock &&
                  !new_low[`IPRS_LOCK_BIT])) begin
              s_d.lock = new_low[`IPRS_LOCK_BIT];
            end
          end
        endcase
      end else begin
        s_d.seq = IPRS_IDLE;
      end
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;
    // registered routing of every peripheral input
    for (int i = 0; i < 8; i++) begin
      s_d.periph[i] = route(pin_in, s_q.sel[i]);
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= reset_state();
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  // all straight from the state register
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign pin_config_lock = s_q.lock;
  assign ext_irq_one = s_q.periph[0];
  assign ext_irq_two = s_q.periph[1];
  assign timer_two_ext_clk = s_q.periph[2];
  assign timer_three_ext_clk = s_q.periph[3];
  assign timer_four_ext_clk = s_q.periph[4];
  assign timer_five_ext_clk = s_q.periph[5];
  assign capture_one_input = s_q.periph[6];
  assign capture_two_input = s_q.periph[7];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic is_sel_addr;
  assign is_sel_addr = wr_w[32] && s_q.awaddr != `IPRS_OFF_OSC;

  locked_write_a: assert property (
    wr_do && s_q.lock && is_sel_addr |=> $stable(s_q.sel))
    else $error("selector changed while locked");

  route_pin_a: assert property (
    int'(s_q.sel[0]) < NUM_PINS |=>
      ext_irq_one == $past(pin_in[s_q.sel[0]]))
    else $error("peripheral input does not follow selected pin");

  irq1_zero_a: assert property (
    arvalid && arready && araddr == `IPRS_OFF_IRQ1 |=>
      rvalid && rdata[7:0] == 8'h00 && rdata[31:13] == 19'h0_0000)
    else $error("unimplemented bits of register 0 not zero");

  irq2_zero_a: assert property (
    arvalid && arready && araddr == `IPRS_OFF_IRQ2 |=>
      rvalid && rdata[31:5] == 27'h000_0000)
    else $error("unimplemented bits of register 1 not zero");

  dual_zero_a: assert property (
    arvalid && arready && (araddr == `IPRS_OFF_TMR23 ||
      araddr == `IPRS_OFF_TMR45 || araddr == `IPRS_OFF_CAP12) |=>
      rvalid && rdata[7:5] == 3'h0 && rdata[15:13] == 3'h0)
    else $error("unimplemented bits of a dual register not zero");

  reset_sel_a: assert property (
    $rose(aresetn) |-> s_q.sel == {8{`IPRS_SEL_RESET}} && !ext_irq_one)
    else $error("selectors not all ones after reset");

  lock_seq_a: assert property (
    $changed(s_q.lock) |-> $past(s_q.seq) == IPRS_ARMED)
    else $error("lock changed without unlock sequence");

  blocked_resp_a: assert property (
    wr_do && s_q.lock && is_sel_addr |=>
      bvalid && bresp == `IPRS_RESP_OKAY)
    else $error("blocked write not answered okay");

  one_way_a: assert property (
    s_q.lock && single_session_lock_cfg |=> s_q.lock)
    else $error("one-way lock was cleared");

  absent_pin_a: assert property (
    int'(s_q.sel[1]) >= NUM_PINS |=> !ext_irq_two)
    else $error("absent pin did not read as ground");

  irq1_field_a: assert property (
    arvalid && arready && araddr == `IPRS_OFF_IRQ1 |=>
      rdata[12:8] == $past(s_q.sel[0]))
    else $error("interrupt 1 field misplaced on read");

  tmr23_field_a: assert property (
    arvalid && arready && araddr == `IPRS_OFF_TMR23 |=>
      rdata[12:8] == $past(s_q.sel[3]) &&
      rdata[4:0] == $past(s_q.sel[2]))
    else $error("timer 2 or 3 field misplaced on read");

  tmr45_field_a: assert property (
    arvalid && arready && araddr == `IPRS_OFF_TMR45 |=>
      rdata[12:8] == $past(s_q.sel[5]) &&
      rdata[4:0] == $past(s_q.sel[4]))
    else $error("timer 4 or 5 field misplaced on read");

  cap12_field_a: assert property (
    arvalid && arready && araddr == `IPRS_OFF_CAP12 |=>
      rdata[12:8] == $past(s_q.sel[7]) &&
      rdata[4:0] == $past(s_q.sel[6]))
    else $error("capture 1 or 2 field misplaced on read");

  unmapped_read_a: assert property (
    arvalid && arready && !rd_w[32] |=>
      rresp == `IPRS_RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  unlock_seen_c: cover property (s_q.seq == IPRS_ARMED);
  lock_set_c: cover property ($rose(s_q.lock));
  blocked_write_c: cover property (wr_do && s_q.lock && is_sel_addr);
  sel_read_c: cover property (rvalid && rready && rresp == 2'h0);

endmodule : iprs_top

// ===== logic/iprs_defines.svh
`ifndef IPRS_DEFINES_SVH
`define IPRS_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define IPRS_OFF_IRQ1 8'h00
`define IPRS_OFF_IRQ2 8'h04
`define IPRS_OFF_TMR23 8'h0C
`define IPRS_OFF_TMR45 8'h10
`define IPRS_OFF_CAP12 8'h1C
`define IPRS_OFF_OSC 8'h40

// ****************************************
// field positions and values
// ****************************************
`define IPRS_HI_LSB 8
`define IPRS_LO_LSB 0
`define IPRS_LOCK_BIT 6
`define IPRS_SEL_RESET 5'h1F
`define IPRS_LOCK_RESET 1'b0
`define IPRS_KEY_ONE 8'h46
`define IPRS_KEY_TWO 8'h57
`define IPRS_RESP_OKAY 2'h0
`define IPRS_RESP_SLVERR 2'h2

`endif

// ===== logic/iprs_pkg.sv
package iprs_pkg;

  // unlock sequence progress
  typedef enum logic [1:0] {
    IPRS_IDLE,
    IPRS_KEY1_SEEN,
    IPRS_ARMED
  } iprs_seq_e;

  typedef logic [4:0] iprs_sel_t;

  // whole state of the block
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    iprs_sel_t [7:0] sel;
    logic lock;
    iprs_seq_e seq;
    logic [7:0] periph;
  } iprs_state_s;

endpackage : iprs_pkg

// ===== tb/iprs_pin_model.sv
`timescale 1ns/1ps
// ****************************************
// remappable pin drivers
// ****************************************
module iprs_pin_model #(
  parameter int N = 31
) (
  // clock
  input wire logic aclk,
  // pin levels
  output logic [N-1:0] pin_in
);
  // fresh random levels after every rising edge, so a stale route shows up
  initial begin
    pin_in = '0;
    forever begin
      @(posedge aclk);
      pin_in <= N'($urandom);
    end
  end
endmodule : iprs_pin_model

// ===== tb/input_pin_remap_select_bench.sv
`timescale 1ns/1ps
`include "iprs_defines.svh"
module input_pin_remap_select_bench import iprs_pkg::*;;
  localparam logic [7:0] AD [5] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h1C};
  localparam logic [15:0] MK [5] = '{16'h1F00, 16'h001F, 16'h1F1F,
    16'h1F1F, 16'h1F1F};
  localparam int RI [8] = '{0, 1, 2, 2, 3, 3, 4, 4};
  localparam bit HI [8] = '{1, 0, 0, 1, 0, 1, 0, 1};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ss;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  wire logic awready, wready, bvalid, arready, rvalid, lock;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [30:0] pins;
  wire logic [7:0] outs;
  logic [30:0] pin_q;
  logic [15:0] shadow [5];
  logic lk;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;

  // ****************************************
  // design and pins
  // ****************************************
  iprs_top u_iprs_top (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .single_session_lock_cfg(ss), .pin_config_lock(lock), .pin_in(pins),
    .ext_irq_one(outs[0]), .ext_irq_two(outs[1]),
    .timer_two_ext_clk(outs[2]), .timer_three_ext_clk(outs[3]),
    .timer_four_ext_clk(outs[4]), .timer_five_ext_clk(outs[5]),
    .capture_one_input(outs[6]), .capture_two_input(outs[7]));
  iprs_pin_model #(.N(31)) u_iprs_pin_model (.aclk(aclk), .pin_in(pins));

  // clock, pin history and hang guard
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    pin_q <= pins;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    r = bresp; // bready stays up between writes
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    d = rdata;
    r = rresp; // rready stays up between reads
  endtask : rd

  // expected register update, blocked while locked
  task automatic wsel(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] m;
    logic [1:0] r;
    m = MK[i] & {{8{s[1]}}, {8{s[0]}}};
    wr(AD[i], d, s, r);
    chk("bresp", 32'(r), 32'(`IPRS_RESP_OKAY));
    if (!lk) shadow[i] = (shadow[i] & ~m) | (d[15:0] & m);
  endtask : wsel

  task automatic check_regs;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 5; i++) begin
      rd(AD[i], d, r);
      chk("selector", d, {16'h0000, shadow[i]});
      chk("rresp", 32'(r), 32'(`IPRS_RESP_OKAY));
    end
    chk("lock", 32'(lock), 32'(lk));
  endtask : check_regs

  task automatic check_routes;
    logic [4:0] s;
    repeat (4) begin
      @(negedge aclk);
      for (int i = 0; i < 8; i++) begin
        s = HI[i] ? shadow[RI[i]][12:8] : shadow[RI[i]][4:0];
        chk("route", 32'(outs[i]), 32'(s < 31 ? pin_q[s] : 1'b0));
      end
    end
    @(posedge aclk);
  endtask : check_routes

  task automatic unlk(input logic v);
    logic [1:0] r;
    wr(`IPRS_OFF_OSC, 32'(`IPRS_KEY_ONE), 4'h1, r);
    wr(`IPRS_OFF_OSC, 32'(`IPRS_KEY_TWO), 4'h1, r);
    wr(`IPRS_OFF_OSC, {25'h0, v, 6'h00}, 4'h1, r);
    lk = (lk && ss) ? 1'b1 : v;
  endtask : unlk

  task automatic reset_model;
    lk = 1'b0;
    for (int i = 0; i < 5; i++) shadow[i] = MK[i];
  endtask : reset_model

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ss} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    d = $urandom(33);
    reset_model();
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_regs();
    check_routes();
    $display("test reset done");
    for (int i = 0; i < 5; i++) wsel(i, 32'hFFFF_FFFE, 4'hF);
    repeat (4) begin
      repeat (6) wsel($urandom_range(4), $urandom, 4'($urandom));
      check_regs();
      check_routes();
    end
    $display("test write route done");
    unlk(1'b1);
    rd(`IPRS_OFF_OSC, d, r);
    chk("ctl", 32'(d[`IPRS_LOCK_BIT]), 32'h0000_0001);
    wsel(0, 32'h0000_0000, 4'h3);
    wr(`IPRS_OFF_OSC, 32'(`IPRS_KEY_ONE), 4'h1, r);
    wsel(1, 32'h0000_0000, 4'h3);
    wr(`IPRS_OFF_OSC, 32'(`IPRS_KEY_TWO), 4'h1, r);
    wr(`IPRS_OFF_OSC, 32'h0000_0000, 4'h1, r);
    check_regs();
    unlk(1'b0);
    wsel(2, 32'h0000_0305, 4'h3);
    check_regs();
    $display("test lock done");
    ss <= 1'b1;
    unlk(1'b1);
    unlk(1'b0);
    wsel(3, 32'h0000_0000, 4'h3);
    check_regs();
    wr(8'h08, 32'h0000_0000, 4'h3, r);
    chk("bresp", 32'(r), 32'(`IPRS_RESP_SLVERR));
    rd(8'h20, d, r);
    chk("rresp", 32'(r), 32'(`IPRS_RESP_SLVERR));
    chk("rdata", d, 32'h0000_0000);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reset_model();
    check_regs();
    $display("test single session done");
    report_and_stop();
  end
endmodule : input_pin_remap_select_bench
